// *** common/timer_pkg.sv ***
package timer_pkg;

  // ****************************************
  // Register byte offsets on the bus.
  // ****************************************
  localparam logic [7:0] ADR_CTRL_A = 8'h00;
  localparam logic [7:0] ADR_CTRL_B = 8'h04;
  localparam logic [7:0] ADR_COUNT = 8'h08;
  localparam logic [7:0] ADR_CMP_A = 8'h0C;
  localparam logic [7:0] ADR_CMP_B = 8'h10;
  localparam logic [7:0] ADR_FLAGS = 8'h14;
  localparam logic [7:0] ADR_PORT = 8'h18;

  // ****************************************
  // Field positions and reset values.
  // ****************************************
  localparam int CA_OUT_A_LSB = 6;
  localparam int CA_OUT_B_LSB = 4;
  localparam int CB_FORCE_A = 7;
  localparam int CB_FORCE_B = 6;
  localparam int CB_WAVE_HI = 3;
  localparam int FL_OVF = 0;
  localparam int FL_MATCH_A = 1;
  localparam int FL_MATCH_B = 2;
  localparam int PT_DIR_A = 0;
  localparam int PT_DIR_B = 1;
  localparam int PT_VAL_A = 2;
  localparam int PT_VAL_B = 3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;

  // ****************************************
  // Mode and clock select encodings.
  // ****************************************
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_CMP = 3'h7;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_WIDTH = 10;

  // ****************************************
  // Types.
  // ****************************************
  typedef struct packed {
    logic level;
    logic oe;
  } pin_t;

  typedef enum logic [1:0] {
    CNT_UP = 2'b01,
    CNT_DOWN = 2'b10
  } cnt_dir_t;

endpackage : timer_pkg

// *** logic/wave_timer.sv ***
module wave_timer
  import timer_pkg::*;
#(
  parameter int PRE_W = PRE_WIDTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ext_count_i,
  input wire logic [2:0] vec_ack_i,
  output logic [2:0] flags_o,
  output pin_t pin_a_o,
  output pin_t pin_b_o
);

  // ****************************************
  // Elaboration check.
  // ****************************************
  if (PRE_W < PRE_WIDTH) begin : g_chk
    $error("Prescaler too narrow for the divide by 1024 tap.");
  end

  // ****************************************
  // Functions.
  // ****************************************
  // Next level of one compare output for one timer event.
  function automatic logic wave_next(
    input logic cur,
    input logic [1:0] com,
    input logic match,
    input logic at_top,
    input logic up,
    input logic fast,
    input logic pc,
    input logic is_a,
    input logic hi,
    input logic ign
  );
    logic r;
    r = cur;
    if (!fast && !pc) begin
      if (match) begin
        unique case (com)
          2'd1: r = ~cur;
          2'd2: r = 1'b0;
          2'd3: r = 1'b1;
          default: r = cur;
        endcase
      end
    end else if (com == 2'd1) begin
      if (is_a && hi && match) begin
        r = ~cur;
      end
    end else if (com[1] && fast) begin
      if (match && !ign) begin
        r = com[0];
      end
      if (at_top) begin
        r = ~com[0];
      end
    end else if (com[1]) begin
      if (match && !ign) begin
        r = up ? com[0] : ~com[0];
      end
      if (at_top && ign) begin
        r = ~com[0];
      end
    end
    return r;
  endfunction : wave_next

  // ****************************************
  // State.
  // ****************************************
  logic ack;
  logic [31:0] rdata;
  logic [1:0] out_mode_a;
  logic [1:0] out_mode_b;
  logic [1:0] wave_mode_lo;
  logic wave_mode_hi_bit;
  logic [2:0] clock_select_field;
  logic [7:0] timer_count_value;
  logic [7:0] cmp_buf_a;
  logic [7:0] cmp_buf_b;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [3:0] port_ctrl;
  logic overflow_flag;
  logic match_flag_a;
  logic match_flag_b;
  logic block_match;
  logic wave_out_a;
  logic wave_out_b;
  cnt_dir_t dir;
  logic [PRE_W-1:0] pre;
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;

  // ****************************************
  // Bus decode.
  // ****************************************
  // A write lands at the edge where the master sees ack high.
  wire req = cyc_i & stb_i;
  wire wr = req & we_i & ack & sel_i[0];
  wire wr_ctrl_a = wr & (adr_i == ADR_CTRL_A);
  wire wr_ctrl_b = wr & (adr_i == ADR_CTRL_B);
  wire wr_count = wr & (adr_i == ADR_COUNT);
  wire wr_cmp_a = wr & (adr_i == ADR_CMP_A);
  wire wr_cmp_b = wr & (adr_i == ADR_CMP_B);
  wire wr_flags = wr & (adr_i == ADR_FLAGS);
  wire wr_port = wr & (adr_i == ADR_PORT);
  wire [7:0] wd = dat_i[7:0];

  // ****************************************
  // Mode decode.
  // ****************************************
  wire [2:0] wave_mode_sel = {wave_mode_hi_bit, wave_mode_lo};
  wire is_fast = (wave_mode_lo == 2'd3);
  wire is_pc = (wave_mode_lo == 2'd1);
  wire is_pwm = is_fast | is_pc;
  wire is_ctc = (wave_mode_sel == WM_CTC);
  wire [7:0] top_val = (wave_mode_hi_bit | is_ctc) ? compare_value_a : CNT_MAX;
  wire at_top = (timer_count_value == top_val);
  wire at_bottom = (timer_count_value == CNT_BOTTOM);
  wire going_up = (dir == CNT_UP) & ~at_top;

  // ****************************************
  // Timer clock source.
  // ****************************************
  // Taps fire once per divide period of the free-running prescaler.
  wire tap8 = &pre[2:0];
  wire tap64 = &pre[5:0];
  wire tap256 = &pre[7:0];
  wire tap1024 = &pre[9:0];
  wire ext_rise = ext_s2 & ~ext_s3;
  wire ext_fall = ~ext_s2 & ext_s3;
  logic tick;
  always_comb begin
    unique case (clock_select_field)
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = tap8;
      CS_DIV64: tick = tap64;
      CS_DIV256: tick = tap256;
      CS_DIV1024: tick = tap1024;
      CS_EXT_FALL: tick = ext_fall;
      CS_EXT_RISE: tick = ext_rise;
    endcase
  end

  // ****************************************
  // Compare and flag events.
  // ****************************************
  wire raw_a = timer_count_value == compare_value_a;
  wire raw_b = timer_count_value == compare_value_b;
  wire match_a = tick & raw_a & ~block_match;
  wire match_b = tick & raw_b & ~block_match;
  wire ign_a = is_pwm & (compare_value_a == top_val) & out_mode_a[1];
  wire ign_b = is_pwm & (compare_value_b == top_val) & out_mode_b[1];
  wire ovf_cond = is_pc ? at_bottom :
                  (wave_mode_sel == WM_FAST_CMP) ? at_top :
                  (timer_count_value == CNT_MAX);
  wire set_ovf = tick & ovf_cond;
  wire force_a = wr_ctrl_b & wd[CB_FORCE_A] & ~is_pwm;
  wire force_b = wr_ctrl_b & wd[CB_FORCE_B] & ~is_pwm;
  wire wrap = is_fast | is_ctc;

  // ****************************************
  // Counter next value.
  // ****************************************
  logic [7:0] next_count;
  cnt_dir_t next_dir;
  always_comb begin
    next_count = timer_count_value;
    next_dir = dir;
    if (wr_count) begin
      next_count = wd;
    end else if (tick && is_pc) begin
      if (at_top) begin
        next_dir = CNT_DOWN;
        next_count = timer_count_value - 8'h01;
      end else if (at_bottom) begin
        next_dir = CNT_UP;
        next_count = timer_count_value + 8'h01;
      end else if (dir == CNT_UP) begin
        next_count = timer_count_value + 8'h01;
      end else begin
        next_count = timer_count_value - 8'h01;
      end
    end else if (tick) begin
      next_dir = CNT_UP;
      next_count = (wrap && at_top) ? CNT_BOTTOM : timer_count_value + 8'h01;
    end
  end

  // ****************************************
  // Waveform next values.
  // ****************************************
  // A forced strobe runs the non-PWM action and nothing else.
  logic next_wave_a;
  logic next_wave_b;
  always_comb begin
    next_wave_a = wave_out_a;
    next_wave_b = wave_out_b;
    if (force_a) begin
      next_wave_a = wave_next(wave_out_a, out_mode_a, 1'b1, 1'b0, 1'b1,
                              1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    end else if (tick) begin
      next_wave_a = wave_next(wave_out_a, out_mode_a, match_a, at_top,
                              going_up, is_fast, is_pc, 1'b1,
                              wave_mode_hi_bit, ign_a);
    end
    if (force_b) begin
      next_wave_b = wave_next(wave_out_b, out_mode_b, 1'b1, 1'b0, 1'b1,
                              1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    end else if (tick) begin
      next_wave_b = wave_next(wave_out_b, out_mode_b, match_b, at_top,
                              going_up, is_fast, is_pc, 1'b0,
                              wave_mode_hi_bit, ign_b);
    end
  end

  // ****************************************
  // Read mux.
  // ****************************************
  always_comb begin
    unique case (adr_i)
      ADR_CTRL_A: rdata = {24'h0, out_mode_a, out_mode_b, 2'b00, wave_mode_lo};
      ADR_CTRL_B: rdata = {24'h0, 4'h0, wave_mode_hi_bit, clock_select_field};
      ADR_COUNT: rdata = {24'h0, timer_count_value};
      ADR_CMP_A: rdata = {24'h0, cmp_buf_a};
      ADR_CMP_B: rdata = {24'h0, cmp_buf_b};
      ADR_FLAGS: rdata = {29'h0, flags_o};
      ADR_PORT: rdata = {28'h0, port_ctrl};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Bus handshake.
  // ****************************************
  // Ack answers one cycle after the request and drops the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack <= req & ~ack;
      dat_o <= rdata;
    end
  end

  // ****************************************
  // Control registers.
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_mode_a <= 2'b00;
      out_mode_b <= 2'b00;
      wave_mode_lo <= 2'b00;
      wave_mode_hi_bit <= 1'b0;
      clock_select_field <= CS_STOP;
      port_ctrl <= 4'h0;
    end else begin
      if (wr_ctrl_a) begin
        out_mode_a <= wd[CA_OUT_A_LSB+:2];
        out_mode_b <= wd[CA_OUT_B_LSB+:2];
        wave_mode_lo <= wd[1:0];
      end
      if (wr_ctrl_b) begin
        wave_mode_hi_bit <= wd[CB_WAVE_HI];
        clock_select_field <= wd[2:0];
      end
      if (wr_port) begin
        port_ctrl <= wd[3:0];
      end
    end
  end

  // ****************************************
  // Compare registers.
  // ****************************************
  // Non-PWM modes load the active value at once, PWM modes at TOP.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_buf_a <= REG_RESET;
      cmp_buf_b <= REG_RESET;
      compare_value_a <= REG_RESET;
      compare_value_b <= REG_RESET;
    end else begin
      if (wr_cmp_a) begin
        cmp_buf_a <= wd;
      end
      if (wr_cmp_b) begin
        cmp_buf_b <= wd;
      end
      if (!is_pwm || (tick && at_top)) begin
        compare_value_a <= cmp_buf_a;
        compare_value_b <= cmp_buf_b;
      end
    end
  end

  // ****************************************
  // Counter and waveform state.
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_count_value <= REG_RESET;
      dir <= CNT_UP;
      block_match <= 1'b0;
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      timer_count_value <= next_count;
      dir <= next_dir;
      block_match <= wr_count | (block_match & ~tick);
      wave_out_a <= next_wave_a;
      wave_out_b <= next_wave_b;
    end
  end

  // ****************************************
  // Flags.
  // ****************************************
  // A hardware set in the clearing cycle wins over the clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag <= 1'b0;
      match_flag_a <= 1'b0;
      match_flag_b <= 1'b0;
    end else begin
      overflow_flag <= set_ovf | (overflow_flag & ~vec_ack_i[FL_OVF] &
                       ~(wr_flags & wd[FL_OVF]));
      match_flag_a <= match_a | (match_flag_a & ~vec_ack_i[FL_MATCH_A] &
                      ~(wr_flags & wd[FL_MATCH_A]));
      match_flag_b <= match_b | (match_flag_b & ~vec_ack_i[FL_MATCH_B] &
                      ~(wr_flags & wd[FL_MATCH_B]));
    end
  end

  // ****************************************
  // Prescaler and external pin sampling.
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre <= '0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      pre <= pre + 1'b1;
      ext_s1 <= ext_count_i;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // ****************************************
  // Outputs.
  // ****************************************
  // The compare output replaces the port value; direction gates the driver.
  assign ack_o = ack;
  assign flags_o = {match_flag_b, match_flag_a, overflow_flag};
  assign pin_a_o.level = (|out_mode_a) ? wave_out_a : port_ctrl[PT_VAL_A];
  assign pin_a_o.oe = port_ctrl[PT_DIR_A];
  assign pin_b_o.level = (|out_mode_b) ? wave_out_b : port_ctrl[PT_VAL_B];
  assign pin_b_o.oe = port_ctrl[PT_DIR_B];

endmodule : wave_timer

// *** sim/tb_eight_bit_timer_waveform_regs.sv ***
module tb_eight_bit_timer_waveform_regs
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Stimulus and bus tasks
  // ****
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic ext_count_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [2:0] vec_ack_i = 3'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [2:0] flags_o;
  pin_t pin_a_o;
  pin_t pin_b_o;
  logic [7:0] q;
  int n_errors = 0;
  int cmp_count = 0;
  int ticks = 0;

  // Clock at 50 MHz.
  always #10 clk_i = ~clk_i;

  wave_timer #(.PRE_W(PRE_WIDTH)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_count_i(ext_count_i), .vec_ack_i(vec_ack_i), .flags_o(flags_o),
    .pin_a_o(pin_a_o), .pin_b_o(pin_b_o)
  );

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // Cuts a hung run short.
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 5000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    wb(a, 1'b0, 8'h00);
    chk(nm, e, q);
  endtask : rd

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    logic [7:0] adrs [4] = '{ADR_CTRL_A, ADR_CTRL_B, ADR_COUNT, ADR_FLAGS};
    foreach (adrs[i]) rd(adrs[i], REG_RESET, "reset value");
  endtask : t_reset

  task automatic t_reserved();
    wr(ADR_CTRL_A, 8'hFF);
    rd(ADR_CTRL_A, 8'hF3, "control a");
    wr(ADR_CTRL_A, 8'h00);
    wr(ADR_CTRL_B, 8'hF0);
    rd(ADR_CTRL_B, 8'h00, "control b");
    rd(8'h1C, 8'h00, "unmapped");
  endtask : t_reserved

  // Forced matches in the clear-on-match mode walk set, clear and toggle.
  task automatic t_force();
    logic [1:0] md [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(ADR_COUNT, 8'h55);
    for (int c = 0; c < 2; c++) begin
      foreach (md[i]) begin
        wr(ADR_CTRL_A, ({6'h00, md[i]} << (c ? 4 : 6)) | 8'h02);
        wr(ADR_CTRL_B, c ? 8'h40 : 8'h80);
        repeat (2) @(posedge clk_i);
        chk("forced level", {7'h00, ex[i]}, {7'h00, c ? pin_b_o.level : pin_a_o.level});
      end
    end
    chk("flags after force", 8'h00, {5'h00, flags_o});
    rd(ADR_COUNT, 8'h55, "count after force");
  endtask : t_force

  task automatic run(input logic [2:0] cs, input int n);
    wr(ADR_CTRL_B, {5'h00, cs});
    repeat (n) @(posedge clk_i);
    wr(ADR_CTRL_B, 8'h00);
  endtask : run

  task automatic t_match();
    wr(ADR_CTRL_A, 8'h00);
    wr(ADR_CMP_A, 8'h30);
    wr(ADR_CMP_B, 8'h31);
    wr(ADR_COUNT, 8'h30);
    wr(ADR_FLAGS, 8'h07);
    run(CS_DIV1, 10);
    chk("match flags", 8'h04, {5'h00, flags_o});
    vec_ack_i <= 3'h4;
    @(posedge clk_i);
    vec_ack_i <= 3'h0;
    @(posedge clk_i);
    chk("vector clear", 8'h00, {5'h00, flags_o});
    wr(ADR_COUNT, 8'hF0);
    run(CS_DIV1, 30);
    chk("overflow flag", 8'h01, {5'h00, flags_o});
    wr(ADR_FLAGS, 8'h01);
    rd(ADR_FLAGS, 8'h00, "flags clear");
    // The clear-on-match mode wraps at compare A on the third of five ticks from 0x2E.
    wr(ADR_CTRL_A, 8'h02);
    wr(ADR_COUNT, 8'h2E);
    run(CS_DIV1, 2);
    rd(ADR_COUNT, 8'h02, "count after top");
    rd(ADR_FLAGS, 8'h02, "flags in clear-on-match");
  endtask : t_match

  // Counts high cycles of both pins over whole periods of a running PWM.
  task automatic meas(input logic [7:0] ca, output int ha, output int hb);
    wr(ADR_CTRL_B, 8'h00);
    wr(ADR_FLAGS, 8'h07);
    wr(ADR_COUNT, 8'h00);
    wr(ADR_CTRL_A, ca);
    wr(ADR_CTRL_B, 8'h09);
    repeat (40) @(posedge clk_i);
    ha = 0;
    hb = 0;
    repeat (90) begin
      @(posedge clk_i);
      if (pin_a_o.level === 1'b1) ha++;
      if (pin_b_o.level === 1'b1) hb++;
    end
  endtask : meas

  task automatic t_pwm();
    int ha;
    int hb;
    int ha2;
    int hb2;
    logic [1:0] wm [2] = '{2'h3, 2'h1};
    wr(ADR_CMP_A, 8'h09);
    wr(ADR_CMP_B, 8'h03);
    foreach (wm[i]) begin
      meas({6'h38, wm[i]}, ha, hb);
      chk("overflow in pwm", 8'h01, {7'h00, flags_o[FL_OVF]});
      wr(ADR_FLAGS, 8'h07);
      meas({6'h2C, wm[i]}, ha2, hb2);
      chk("a high count mode 3", 8'h00, ha[7:0]);
      chk("a high count mode 2", 8'h5A, ha2[7:0]);
      chk("b high sum", 8'h5A, 8'(hb + hb2));
      chk("b mode 2 below 3", 8'h01, {7'h00, hb < hb2});
    end
  endtask : t_pwm

  task automatic t_ext();
    logic [2:0] cs [2] = '{CS_EXT_RISE, CS_EXT_FALL};
    wr(ADR_CTRL_A, 8'h00);
    foreach (cs[i]) begin
      wr(ADR_CTRL_B, 8'h00);
      wr(ADR_COUNT, 8'h00);
      wr(ADR_CTRL_B, {5'h00, cs[i]});
      repeat (3) begin
        ext_count_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext_count_i <= 1'b0;
        repeat (4) @(posedge clk_i);
      end
      wr(ADR_CTRL_B, 8'h00);
      rd(ADR_COUNT, 8'h03, "external count");
    end
  endtask : t_ext

  // A run of whole divide periods holds a fixed number of prescaler taps.
  task automatic t_presc();
    logic [2:0] cs [4] = '{CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
    int len [4] = '{61, 61, 253, 1021};
    logic [7:0] ex [4] = '{8'h08, 8'h01, 8'h01, 8'h01};
    wr(ADR_CTRL_A, 8'h00);
    foreach (cs[i]) begin
      wr(ADR_COUNT, 8'h00);
      run(cs[i], len[i]);
      rd(ADR_COUNT, ex[i], "prescaled count");
    end
  endtask : t_presc

  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    wr(ADR_PORT, 8'h0F);
    @(posedge clk_i);
    chk("pin a", 8'h03, {6'h00, pin_a_o});
    t_reserved();
    t_force();
    t_match();
    t_pwm();
    t_ext();
    t_presc();
    complete_run();
  end
endmodule : tb_eight_bit_timer_waveform_regs

// *** sim/wave_timer_properties.sv ***
module wave_timer_properties
  import timer_pkg::*;
#(
  parameter int PRE_W = PRE_WIDTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic ext_count_i,
  input wire logic [2:0] vec_ack_i,
  input wire logic [2:0] flags_o,
  input wire pin_t pin_a_o,
  input wire pin_t pin_b_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Shadow state
  // ****
  logic [7:0] ca_sh;
  logic [7:0] pt_sh;
  logic [2:0] cs_sh;
  logic [1:0] run_q;
  // Writes decoded from the bus; stop3 marks a timer stopped for three cycles.
  wire wr_ok = ack_o && we_i && sel_i[0];
  wire wr_ca = wr_ok && adr_i == ADR_CTRL_A;
  wire wr_cb = wr_ok && adr_i == ADR_CTRL_B;
  wire wr_pt = wr_ok && adr_i == ADR_PORT;
  wire stop3 = cs_sh == CS_STOP && run_q == 2'h0;

  // Shadows follow each accepted write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ca_sh <= REG_RESET;
      pt_sh <= REG_RESET;
      cs_sh <= CS_STOP;
    end else begin
      if (wr_ca) ca_sh <= dat_i[7:0];
      if (wr_pt) pt_sh <= dat_i[7:0];
      if (wr_cb) cs_sh <= dat_i[2:0];
    end
  end

  // Remembers whether the timer ran in the last two cycles.
  always_ff @(posedge clk_i) begin
    if (rst_i) run_q <= 2'h0;
    else run_q <= {run_q[0], cs_sh != CS_STOP};
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_resv_a_zero: assert property (ack_o && !we_i && adr_i == ADR_CTRL_A |-> dat_o[3:2] == 2'h0)
    else $error("control a spare bits set");
  a_resv_b_zero: assert property (ack_o && !we_i && adr_i == ADR_CTRL_B |-> dat_o[7:4] == 4'h0)
    else $error("control b upper bits set");
  a_reset_clear: assert property ($fell(rst_i) |-> flags_o == 3'h0 && pin_a_o == 2'h0 && pin_b_o == 2'h0)
    else $error("outputs not cleared by reset");
  a_stop_no_flag: assert property (stop3 |-> (flags_o & ~$past(flags_o)) == 3'h0)
    else $error("flag set while stopped");
  a_vec_clears: assert property (cs_sh == CS_STOP && vec_ack_i != 3'h0 |=> (flags_o & $past(vec_ack_i)) == 3'h0)
    else $error("vector did not clear flag");
  a_oe_follow: assert property (wr_pt |=> pin_a_o.oe == $past(dat_i[PT_DIR_A]) && pin_b_o.oe == $past(dat_i[PT_DIR_B]))
    else $error("pin enable not from direction bit");
  a_port_lvl_a: assert property (ca_sh[7:6] == 2'h0 && $stable(ca_sh) && $stable(pt_sh) |-> pin_a_o.level == pt_sh[PT_VAL_A])
    else $error("pin a not port level");
  a_port_lvl_b: assert property (ca_sh[5:4] == 2'h0 && $stable(ca_sh) && $stable(pt_sh) |-> pin_b_o.level == pt_sh[PT_VAL_B])
    else $error("pin b not port level");
endmodule : wave_timer_properties

bind wave_timer wave_timer_properties #(.PRE_W(PRE_W)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .ext_count_i(ext_count_i), .vec_ack_i(vec_ack_i), .flags_o(flags_o),
  .pin_a_o(pin_a_o), .pin_b_o(pin_b_o)
);
